// ==== design/operating_mode_power_control.sv ====
// Purpose: normal, slow, standby and halt control with oscillator gating
// Assumes: cpu, oscillators and wake sources share clk_sys
// Notes: Wishbone classic slave, ack one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
`include "opmode_map.svh"
module operating_mode_power_control #(
  parameter int LONG_COUNT = `STABLE_CYCLES_CRYSTAL,
  parameter int SHORT_COUNT = `STABLE_CYCLES_RC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu side
  input wire logic sleep_exec,
  input wire logic interrupt_enable_instruction,
  input wire logic interrupt_disable_instruction,
  output logic cpu_run,
  output logic isr_branch,
  output logic [11:0] isr_vector,
  output logic resume_next,
  // oscillators
  input wire logic sys_osc_tick,
  output logic sys_clk_high_select_o,
  output logic high_osc_enable,
  output logic low_osc_enable,
  // peripherals and wake sources
  input wire logic [`WAKE_COUNT-1:0] wake_event,
  output logic periph_enable,
  output logic timer_enable,
  output logic watchdog_clear
);
  opmode_pkg::pm_state_t state;
  opmode_pkg::pm_state_t next_state;
  stable_wait_if sw ();

  // timer loads short into a counter sized for long; zero would wrap and run the whole counter range
  if (SHORT_COUNT < 1 || LONG_COUNT < SHORT_COUNT) begin : g_bad_counts
    $error("operating_mode_power_control: counts must satisfy 1 <= short <= long");
  end

  logic sys_clk_high_select;
  logic high_osc_stop;
  logic [1:0] op_mode_field;
  logic power_down_flag;
  logic timeout_flag;
  logic int_enabled;
  logic ext_high_crystal_mode;
  logic ext_crystal_mode;
  logic ext_low_crystal_mode;
  logic bus_req;
  logic wr_ctl;
  logic wr_cfg;
  logic halt_req;
  logic standby_req;
  logic wake_standby;
  logic wake_halt;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i;
  // a write lands on the edge where ack is seen high
  assign wr_ctl = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_OSC_CONTROL;
  assign wr_cfg = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_OSC_CONFIG;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_OSC_CONTROL: begin
        rd_word[`BIT_SYS_CLK_HIGH_SELECT] = sys_clk_high_select;
        rd_word[`BIT_HIGH_OSC_STOP] = high_osc_stop;
        rd_word[`BIT_OP_MODE_HI:`BIT_OP_MODE_LO] = op_mode_field;
      end
      `OFS_STATUS: begin
        rd_word[2:0] = state;
        rd_word[`BIT_POWER_DOWN_FLAG] = power_down_flag;
        rd_word[`BIT_TIMEOUT_FLAG] = timeout_flag;
        rd_word[`BIT_INT_ENABLED] = int_enabled;
      end
      `OFS_OSC_CONFIG: begin
        rd_word[`BIT_EXT_HIGH_CRYSTAL] = ext_high_crystal_mode;
        rd_word[`BIT_EXT_CRYSTAL] = ext_crystal_mode;
        rd_word[`BIT_EXT_LOW_CRYSTAL] = ext_low_crystal_mode;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // unmapped addresses still ack, reading zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator control register
  // ---------------------------------------------------------------
  // select and stop bits land together, so one write may stop and halt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_high_select <= 1'(`RST_OSC_CONTROL >> `BIT_SYS_CLK_HIGH_SELECT);
      high_osc_stop <= 1'b0;
    end else if (wr_ctl) begin
      sys_clk_high_select <= wb_dat_i[`BIT_SYS_CLK_HIGH_SELECT];
      high_osc_stop <= wb_dat_i[`BIT_HIGH_OSC_STOP];
    end
  end

  // mode field clears itself on wake; a software write never races it
  // because execution is stopped while the field holds the halt or standby code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_mode_field <= 2'h0;
    end else if (wr_ctl) begin
      op_mode_field <= wb_dat_i[`BIT_OP_MODE_HI:`BIT_OP_MODE_LO];
    end else if (state == opmode_pkg::ST_RESUME) begin
      op_mode_field <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // oscillator configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_high_crystal_mode <= 1'b0;
      ext_crystal_mode <= 1'b0;
      ext_low_crystal_mode <= 1'b0;
    end else if (wr_cfg) begin
      ext_high_crystal_mode <= wb_dat_i[`BIT_EXT_HIGH_CRYSTAL];
      ext_crystal_mode <= wb_dat_i[`BIT_EXT_CRYSTAL];
      ext_low_crystal_mode <= wb_dat_i[`BIT_EXT_LOW_CRYSTAL];
    end
  end

  // ---------------------------------------------------------------
  // interrupt enable state seen by the wake path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_enabled <= 1'b0;
    end else if (interrupt_enable_instruction) begin
      int_enabled <= 1'b1;
    end else if (interrupt_disable_instruction) begin
      int_enabled <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  assign halt_req = sleep_exec || op_mode_field == `OP_MODE_HALT;
  assign standby_req = op_mode_field == `OP_MODE_STANDBY;
  assign wake_standby = |(wake_event & `WAKE_MASK_STANDBY);
  assign wake_halt = |(wake_event & `WAKE_MASK_HALT);

  always_comb begin
    next_state = state;
    case (state)
      opmode_pkg::ST_RUN: begin
        if (halt_req) begin
          next_state = opmode_pkg::ST_HALT;
        end else if (standby_req) begin
          next_state = opmode_pkg::ST_STANDBY;
        end
      end
      opmode_pkg::ST_STANDBY: begin
        if (wake_standby) begin
          next_state = opmode_pkg::ST_RESUME;
        end
      end
      opmode_pkg::ST_HALT: begin
        if (wake_halt) begin
          next_state = opmode_pkg::ST_STABLE;
        end
      end
      opmode_pkg::ST_STABLE: begin
        if (sw.done) begin
          next_state = opmode_pkg::ST_RESUME;
        end
      end
      opmode_pkg::ST_RESUME: next_state = opmode_pkg::ST_RUN;
      default: next_state = opmode_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= opmode_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end else if (state == opmode_pkg::ST_RUN && next_state == opmode_pkg::ST_HALT) begin
      power_down_flag <= 1'b0;
      timeout_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      // watchdog restarts its count but keeps running
      watchdog_clear <= state == opmode_pkg::ST_RUN && next_state == opmode_pkg::ST_HALT;
    end
  end

  // ---------------------------------------------------------------
  // stabilisation wait
  // ---------------------------------------------------------------
  assign sw.start = state == opmode_pkg::ST_HALT && wake_halt;
  assign sw.long_wait = ext_high_crystal_mode || ext_crystal_mode || ext_low_crystal_mode;
  assign sw.osc_tick = sys_osc_tick;

  stable_wait_timer #(
    .LONG_COUNT(LONG_COUNT),
    .SHORT_COUNT(SHORT_COUNT)
  ) u_stable_wait (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sw(sw)
  );

  // ---------------------------------------------------------------
  // resume path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      isr_branch <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      isr_branch <= state == opmode_pkg::ST_RESUME && int_enabled;
      resume_next <= state == opmode_pkg::ST_RESUME && !int_enabled;
    end
  end

  assign isr_vector = `ISR_VECTOR;

  // ---------------------------------------------------------------
  // clock and enable outputs
  // ---------------------------------------------------------------
  // the stop bit is honoured in any running mode; software keeps the
  // order slow-then-stop, otherwise the core would lose its clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_high_select_o <= 1'b1;
      high_osc_enable <= 1'b1;
      low_osc_enable <= 1'b1;
      cpu_run <= 1'b1;
      periph_enable <= 1'b1;
      timer_enable <= 1'b1;
    end else begin
      sys_clk_high_select_o <= sys_clk_high_select;
      high_osc_enable <= !high_osc_stop && next_state != opmode_pkg::ST_HALT;
      low_osc_enable <= next_state != opmode_pkg::ST_HALT;
      cpu_run <= next_state == opmode_pkg::ST_RUN;
      periph_enable <= next_state == opmode_pkg::ST_RUN;
      timer_enable <= next_state == opmode_pkg::ST_RUN || next_state == opmode_pkg::ST_STANDBY;
    end
  end
endmodule
`default_nettype wire

// ==== design/opmode_map.svh ====
// Purpose: offsets, fields, reset values and counts of the operating-mode controller
// Assumes: 32-bit classic Wishbone slave, byte addresses, one register per word
// Notes: definitions only
// Behaviour
// - clearing high select runs from low oscillator
// - writing one to stop bit halts high oscillator
// - slow mode executes, peripherals follow own enables
// - setting high select returns to normal mode
// - mode field 10 enters standby, oscillators untouched
// - standby keeps low oscillator and enabled timers
// - standby wakes on any listed interrupt
// - wake resumes normal or slow per select bit
// - sleep instruction or mode 01 enters halt
// - halt entry: pd cleared, to set, watchdog cleared
// - halt stops both oscillators, execution, peripherals
// - halt wakes only on five listed sources
// - one write may change stop bit and halt
// - halt wake waits 512 crystal or 16 cycles
// - standby wake has no stabilisation wait
// - interrupts enabled: wake branches to 0x008
// - interrupts disabled: wake continues next instruction
// - mode field sits at control bits 3:2
// - high select sits at control bit 0
`ifndef OPMODE_MAP_SVH
`define OPMODE_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_OSC_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_OSC_CONFIG 8'h08
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_SYS_CLK_HIGH_SELECT 0
`define BIT_HIGH_OSC_STOP 1
`define BIT_OP_MODE_LO 2
`define BIT_OP_MODE_HI 3
`define BIT_POWER_DOWN_FLAG 3
`define BIT_TIMEOUT_FLAG 4
`define BIT_INT_ENABLED 5
`define BIT_EXT_HIGH_CRYSTAL 0
`define BIT_EXT_CRYSTAL 1
`define BIT_EXT_LOW_CRYSTAL 2
`define OP_MODE_HALT 2'h1
`define OP_MODE_STANDBY 2'h2
// ---------------------------------------------------------------
// wake sources, one bit each
// ---------------------------------------------------------------
`define WAKE_COUNT 11
`define WAKE_MASK_STANDBY 11'h7ff
`define WAKE_MASK_HALT 11'h638
// bits: 0 timer0_count 1 timer1_count 2 timer4_count 3 wdt 4 port 5 ext 6 lvd 7 cmp 8 adc 9 touch cmp 10 touch ovf
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define RST_OSC_CONTROL 4'h1
`define RST_OSC_CONFIG 3'h0
`define STABLE_CYCLES_CRYSTAL 512
`define STABLE_CYCLES_RC 16
`define ISR_VECTOR 12'h008
`endif

// ==== design/opmode_pkg.sv ====
// Purpose: types of the operating-mode controller
// Assumes: nothing
// Notes: constants live in opmode_map.svh
package opmode_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STANDBY = 3'b001,
    ST_HALT = 3'b010,
    ST_STABLE = 3'b011,
    ST_RESUME = 3'b100
  } pm_state_t;
endpackage

// ==== design/stable_wait_if.sv ====
// Purpose: link between mode controller and stabilisation counter
// Assumes: single clock
// Notes: start is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface stable_wait_if;
  logic start;
  logic long_wait;
  logic osc_tick;
  logic done;
  modport ctl (output start, output long_wait, output osc_tick, input done);
  modport tmr (input start, input long_wait, input osc_tick, output done);
endinterface
`default_nettype wire

// ==== design/stable_wait_timer.sv ====
// Purpose: counts oscillator cycles after a halt wake
// Assumes: osc_tick is a one-cycle pulse per system oscillator cycle
// Notes: done is a one-cycle pulse at terminal count
`timescale 1ns/100ps
`default_nettype none
`include "opmode_map.svh"
module stable_wait_timer #(
  parameter int LONG_COUNT = `STABLE_CYCLES_CRYSTAL,
  parameter int SHORT_COUNT = `STABLE_CYCLES_RC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  stable_wait_if.tmr sw
);
  localparam int CW = $clog2(LONG_COUNT + 1);
  if (SHORT_COUNT < 1 || LONG_COUNT < SHORT_COUNT) begin : g_bad
    $error("stable_wait_timer: counts must satisfy 1 <= short <= long");
  end
  logic [CW-1:0] remain;
  logic busy;
  // ---------------------------------------------------------------
  // oscillator cycle countdown
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
      busy <= 1'b0;
      sw.done <= 1'b0;
    end else begin
      sw.done <= 1'b0;
      if (sw.start) begin
        remain <= sw.long_wait ? CW'(LONG_COUNT) : CW'(SHORT_COUNT);
        busy <= 1'b1;
      end else if (busy && sw.osc_tick) begin
        remain <= remain - CW'(1);
        if (remain == CW'(1)) begin
          busy <= 1'b0;
          sw.done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/opmode_properties.sv ====
// Purpose: port-level properties of the mode controller
// Assumes: one clock domain, registered outputs
// Notes: bound from the testbench top
`timescale 1ns/100ps
`default_nettype none
`include "opmode_map.svh"
module opmode_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // cpu side
  input wire logic sleep_exec,
  input wire logic interrupt_enable_instruction,
  input wire logic interrupt_disable_instruction,
  input wire logic cpu_run,
  input wire logic isr_branch,
  input wire logic [11:0] isr_vector,
  input wire logic resume_next,
  // oscillators
  input wire logic sys_osc_tick,
  input wire logic sys_clk_high_select_o,
  input wire logic high_osc_enable,
  input wire logic low_osc_enable,
  // peripherals
  input wire logic [`WAKE_COUNT-1:0] wake_event,
  input wire logic periph_enable,
  input wire logic timer_enable,
  input wire logic watchdog_clear
);
  logic in_halt;
  logic in_standby;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // states read back from outputs only, no peeking inside
  assign in_halt = !cpu_run && !low_osc_enable;
  assign in_standby = !cpu_run && timer_enable && !periph_enable;
  property p_sleep_halts;
    sleep_exec && cpu_run && periph_enable |-> ##[1:2] watchdog_clear;
  endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("sleep missed halt");
  property p_halt_off;
    watchdog_clear |-> in_halt && !high_osc_enable && !periph_enable && !timer_enable;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt left a clock on");
  property p_wdc_pulse;
    watchdog_clear |=> !watchdog_clear;
  endproperty
  a_wdc_pulse: assert property (p_wdc_pulse) else $error("watchdog clear too long");
  property p_halt_ignores;
    in_halt && !(|(wake_event & `WAKE_MASK_HALT)) && !(|($past(wake_event) & `WAKE_MASK_HALT)) |=> in_halt;
  endproperty
  a_halt_ignores: assert property (p_halt_ignores) else $error("halt left on foreign event");
  property p_halt_wakes;
    in_halt && |(wake_event & `WAKE_MASK_HALT) |-> ##[1:2] (low_osc_enable && !cpu_run);
  endproperty
  a_halt_wakes: assert property (p_halt_wakes) else $error("halt wake not gated");
  property p_standby_fast;
    in_standby && |wake_event |-> ##[2:3] cpu_run;
  endproperty
  a_standby_fast: assert property (p_standby_fast) else $error("standby wake slow");
  property p_standby_osc;
    in_standby |-> low_osc_enable;
  endproperty
  a_standby_osc: assert property (p_standby_osc) else $error("standby lost low clock");
  property p_isr;
    isr_branch |-> cpu_run && !resume_next && isr_vector == `ISR_VECTOR;
  endproperty
  a_isr: assert property (p_isr) else $error("bad isr branch");
  property p_resume_mode;
    $rose(cpu_run) && sys_clk_high_select_o |-> high_osc_enable;
  endproperty
  a_resume_mode: assert property (p_resume_mode) else $error("normal resume without high clock");
  c_halt_wake: cover property (in_halt ##1 low_osc_enable);
  c_isr: cover property (isr_branch);
  c_next: cover property (resume_next);
endmodule
`default_nettype wire

// ==== testbench/test_operating_mode_power_control.sv ====
// Purpose: directed bench of the mode controller
// Assumes: ack one cycle after strobe
// Notes: short stabilise counts keep the run brief
`timescale 1ns/100ps
`default_nettype none
`include "opmode_map.svh"
module test_operating_mode_power_control;
  localparam int LONG_N = 4;
  localparam int SHORT_N = 2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic sleep_exec = 1'b0, interrupt_enable_instruction = 1'b0, interrupt_disable_instruction = 1'b0;
  logic sys_osc_tick = 1'b0;
  logic [10:0] wake_event = 11'h0;
  logic wb_ack_o, cpu_run, isr_branch, resume_next, sys_clk_high_select_o;
  logic high_osc_enable, low_osc_enable, periph_enable, timer_enable, watchdog_clear;
  logic [11:0] isr_vector;
  int miscompares = 0, check_count = 0, cycles = 0, n_isr = 0, n_next = 0, n_wdc = 0;
  always #2 clk_sys = ~clk_sys;
  operating_mode_power_control #(.LONG_COUNT(LONG_N), .SHORT_COUNT(SHORT_N)) u_operating_mode_power_control (
    .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sleep_exec, .interrupt_enable_instruction, .interrupt_disable_instruction, .cpu_run, .isr_branch,
    .isr_vector, .resume_next, .sys_osc_tick, .sys_clk_high_select_o, .high_osc_enable, .low_osc_enable,
    .wake_event, .periph_enable, .timer_enable, .watchdog_clear);
  // ----
  // pulse counters take the value standing before each edge
  // ----
  always @(posedge clk_sys) begin
    n_isr += int'(isr_branch === 1'b1);
    n_next += int'(resume_next === 1'b1);
    n_wdc += int'(watchdog_clear === 1'b1);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1) miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // s bits: sleep, enable, disable, tick
  task automatic pulse(input logic [3:0] s, input logic [10:0] w);
    @(posedge clk_sys);
    {sys_osc_tick, interrupt_disable_instruction, interrupt_enable_instruction, sleep_exec} <= s;
    wake_event <= w;
    @(posedge clk_sys);
    {sys_osc_tick, interrupt_disable_instruction, interrupt_enable_instruction, sleep_exec} <= 4'h0;
    wake_event <= 11'h0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic run_wait;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cpu_run !== 1'b1 && n < 20);
    check(32'(n >= 2 && n <= 3), 32'h1);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, `OFS_OSC_CONTROL, 32'h0, q);
    check(q, 32'h1);
    wb(1'b0, `OFS_STATUS, 32'h0, q);
    check(q & 32'h1f, 32'h18);
    wb(1'b1, 8'h40, 32'hffff_ffff, q);
    wb(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
  endtask
  task automatic t_slow;
    logic [31:0] q;
    wb(1'b1, `OFS_OSC_CONTROL, 32'h0, q);
    settle(2);
    check(32'({cpu_run, sys_clk_high_select_o, high_osc_enable, low_osc_enable, periph_enable}), 32'h17);
    wb(1'b1, `OFS_OSC_CONTROL, 32'h2, q);
    settle(2);
    check(32'({cpu_run, sys_clk_high_select_o, high_osc_enable, low_osc_enable}), 32'h9);
    wb(1'b1, `OFS_OSC_CONTROL, 32'h1, q);
    settle(2);
    check(32'({cpu_run, sys_clk_high_select_o, high_osc_enable}), 32'h7);
  endtask
  task automatic t_standby(input logic sel, input int b);
    logic [31:0] q;
    int r;
    r = n_next;
    wb(1'b1, `OFS_OSC_CONTROL, {31'h0, sel}, q);
    wb(1'b1, `OFS_OSC_CONTROL, {28'h0, `OP_MODE_STANDBY, 1'b0, sel}, q);
    settle(2);
    check(32'({cpu_run, high_osc_enable, low_osc_enable, periph_enable, timer_enable}), 32'hd);
    pulse(4'h0, 11'h1 << b);
    run_wait();
    check(32'({sys_clk_high_select_o, cpu_run}), {30'h0, sel, 1'b1});
    wb(1'b0, `OFS_OSC_CONTROL, 32'h0, q);
    check(q, {31'h0, sel});
    check(32'(n_next - r), 32'h1);
  endtask
  // ctrl of zero means the sleep instruction enters halt
  task automatic t_halt(input logic [31:0] ctrl, input int b, input logic [2:0] cfg, input logic ie);
    logic [31:0] q;
    int w;
    int i;
    int r;
    w = n_wdc;
    i = n_isr;
    r = n_next;
    wb(1'b1, `OFS_OSC_CONFIG, {29'h0, cfg}, q);
    pulse({2'b0, ~ie, ie} << 1, 11'h0);
    if (ctrl != 32'h0) wb(1'b1, `OFS_OSC_CONTROL, ctrl & 32'h1, q);
    if (ctrl == 32'h0) pulse(4'h1, 11'h0);
    else wb(1'b1, `OFS_OSC_CONTROL, ctrl, q);
    settle(2);
    check(32'({cpu_run, high_osc_enable, low_osc_enable, periph_enable, timer_enable}), 32'h0);
    check(32'(n_wdc - w), 32'h1);
    wb(1'b0, `OFS_STATUS, 32'h0, q);
    check(q & 32'h3f, {26'h0, ie, 5'h12});
    pulse(4'h0, ~`WAKE_MASK_HALT);
    settle(2);
    check(32'(low_osc_enable), 32'h0);
    pulse(4'h0, 11'h1 << b);
    settle(1);
    check(32'({cpu_run, low_osc_enable}), 32'h1);
    repeat ((cfg != 3'h0 ? LONG_N : SHORT_N) - 1) pulse(4'h8, 11'h0);
    settle(3);
    check(32'(cpu_run), 32'h0);
    pulse(4'h8, 11'h0);
    run_wait();
    check(32'(high_osc_enable), {31'h0, ~ctrl[1]});
    settle(1);
    check(32'(n_isr - i), {31'h0, ie});
    check(32'(isr_vector), 32'(`ISR_VECTOR));
    check(32'(n_next - r), {31'h0, ~ie});
  endtask
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_slow();
    for (int b = 0; b < `WAKE_COUNT; b++) t_standby(b[0], b);
    t_halt(32'h5, 3, 3'h0, 1'b1);
    t_halt(32'h0, 4, 3'h1, 1'b0);
    t_halt(32'h0, 5, 3'h2, 1'b1);
    t_halt(32'h5, 10, 3'h0, 1'b0);
    wb(1'b1, `OFS_OSC_CONTROL, 32'h0, q);
    wb(1'b1, `OFS_OSC_CONTROL, 32'h2, q);
    t_halt(32'h6, 9, 3'h4, 1'b1);
    close_out();
  end
endmodule
bind operating_mode_power_control opmode_properties u_opmode_properties (
  .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .sleep_exec, .interrupt_enable_instruction, .interrupt_disable_instruction, .cpu_run, .isr_branch,
  .isr_vector, .resume_next, .sys_osc_tick, .sys_clk_high_select_o, .high_osc_enable, .low_osc_enable,
  .wake_event, .periph_enable, .timer_enable, .watchdog_clear);
`default_nettype wire
